// file: dv/adc_model.sv
// Purpose: eight-converter model answering the controller's convert pulse
// Assumes: one clock, results for all channels arrive together
// Notes: slow stretches the answer; data scrambles outside the done cycle
module adc_model (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic slow, // long conversion time
  input wire logic [15:0] base, // channel n returns base plus n
  input wire logic adc_start, // convert pulse
  output logic adc_done, // results valid pulse
  output logic [127:0] adc_data // eight results
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_r;
  // every channel converts on the same pulse and reports in one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 0;
      adc_done <= 1'b0;
      adc_data <= 128'h0;
    end else begin
      adc_done <= (cnt_r == 1);
      if (adc_start) begin
        cnt_r <= slow ? 12 : 2;
      end else if (cnt_r != 0) begin
        cnt_r <= cnt_r - 1;
      end
      for (int n = 0; n < 8; n++) begin
        // stale results are not held, so a late read cannot pass
        adc_data[16*n +: 16] <= (cnt_r == 1) ? base + 16'(n)
          : ~adc_data[16*n +: 16];
      end
    end
  end
endmodule

// file: dv/daq_ctrl_assertions.sv
// Purpose: port-level checks of the acquisition controller
// Assumes: single clock domain, async active-low reset
// Notes: bound into every controller instance
`include "daq_params.svh"
module daq_ctrl_chk
  import daq_pkg::*;
#(
  parameter int BLINK_CYCLES = 4
) (
  input wire logic clk, // system clock
  input wire logic rstn, // reset, active low
  input wire logic [3:0] addr, // register address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic adc_start, // convert pulse
  input wire logic [23:0] ch_cfg, // channel setup
  input wire logic [11:0] trig_level, // threshold code
  input wire logic [7:0] digital_input_lines, // input pins
  input wire logic [7:0] digital_output_lines, // output pins
  input wire logic jumper_di_led_off, // input led blank
  input wire logic jumper_do_led_off, // output led blank
  input wire logic [7:0] di_led, // input leds
  input wire logic [7:0] do_led, // output leds
  input wire logic usb_enumerating, // enumeration running
  input wire logic usb_configured, // host attached
  input wire logic activity_indicator // activity led
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  int hold_r;
  // cycles the activity led has stood still during enumeration
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_r <= 0;
    end else if (!usb_enumerating || $changed(activity_indicator)) begin
      hold_r <= 0;
    end else begin
      hold_r <= hold_r + 1;
    end
  end
  dout_reset_a: assert property ($rose(rstn) |-> digital_output_lines == 8'h00)
    else $error("digital outputs not low after reset");
  do_led_a: assert property (!jumper_do_led_off |-> do_led == digital_output_lines)
    else $error("output leds differ from output lines");
  do_blank_a: assert property (jumper_do_led_off |-> do_led == 8'h00)
    else $error("output leds lit while blanked");
  // three sync stages plus the agree register settle within four steady samples; the check waits for six
  di_led_a: assert property (($stable(digital_input_lines)
    && $stable(jumper_di_led_off))[*6]
    |-> di_led == (jumper_di_led_off ? 8'h00 : digital_input_lines))
    else $error("input leds wrong");
  chan_cfg_a: assert property (wr && addr == `A_CHCFG
    |=> {8'h0, ch_cfg} == ($past(wdata) & 32'hffffff))
    else $error("channel setup not taken");
  trig_cfg_a: assert property (wr && addr == `A_TRIG
    |=> {20'h0, trig_level} == ($past(wdata) & 32'hfff))
    else $error("trigger level not taken");
  start_pulse_a: assert property ($rose(adc_start) |=> $fell(adc_start))
    else $error("convert pulse longer than one cycle");
  act_dark_a: assert property ((!usb_configured && !usb_enumerating)[*3]
    |-> !activity_indicator)
    else $error("activity led lit without link");
  enum_blink_a: assert property (hold_r <= BLINK_CYCLES + 2)
    else $error("activity led not blinking while enumerating");
  cover property (adc_start);
  cover property (usb_enumerating && activity_indicator);
  cover property (wr && addr == `A_TRIG);
endmodule
bind daq_ctrl daq_ctrl_chk #(.BLINK_CYCLES(BLINK_CYCLES)) chk (.*);

// file: dv/daq_ctrl_test.sv
// Purpose: self-checking bench of the acquisition controller
// Assumes: 10 MHz clk, converter model on the far side
// Notes: short blink period keeps the run brief
`include "daq_params.svh"
module daq_ctrl_test;
  import daq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, adc_start, adc_done, slow = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [127:0] adc_data;
  logic [23:0] ch_cfg;
  logic [11:0] trig_level;
  logic [7:0] digital_input_lines = 8'h00, digital_output_lines, di_led, do_led;
  logic sample_clk_in = 0, sample_clk_out, trig_above = 0, event_count_input = 0;
  logic jumper_di_led_off = 0, jumper_do_led_off = 0, usb_configured = 0, usb_enumerating = 0;
  logic activity_indicator, block_ready, power_indicator;
  logic [15:0] base = 16'h1230;
  int miscompares = 0, tests_run = 0, cycles = 0;
  daq_ctrl #(.BLINK_CYCLES(4)) dut (.*);
  adc_model partner (.clk, .rstn, .slow, .base, .adc_start, .adc_done, .adc_data);
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard: far above the few hundred cycles the scenarios need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_leds;
    wreg(`A_DOUT, 32'ha5);
    digital_input_lines <= 8'h3c;
    idle(4);
    chk("do leds", {24'h0, do_led}, 32'ha5);
    chk("di leds", {24'h0, di_led}, 32'h3c);
    @(posedge clk);
    jumper_di_led_off <= 1'b1;
    jumper_do_led_off <= 1'b1;
    idle(4);
    chk("blanked leds", {16'h0, di_led, do_led}, 32'h0);
    @(posedge clk);
    jumper_di_led_off <= 1'b0;
    jumper_do_led_off <= 1'b0;
    rstn <= 1'b0;
    idle(2);
    chk("dout in reset", {24'h0, digital_output_lines}, 32'h0);
    @(posedge clk);
    rstn <= 1'b1;
  endtask
  task automatic t_chcfg;
    wreg(`A_CHCFG, 32'hfac688);
    rreg(`A_CHCFG, rv);
    chk("chcfg pins", {8'h0, ch_cfg}, 32'hfac688);
    chk("chcfg read", rv, 32'hfac688);
  endtask
  // two conversions, quick then slow converter, each read before the next;
  // the second runs at half gain on channel 0 so calibration is really applied
  task automatic t_sw;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      slow <= i[0];
      base <= 16'h1230 + 16'(i);
      if (i == 1) wreg(`A_CTRL, 32'h40000040);
      wreg(`A_CTRL, 32'h4);
      rv = 32'hffffffff;
      for (int k = 0; k < 40 && rv[5] !== 1'b0; k++) rreg(`A_STATUS, rv);
      rreg(`A_SWDATA, rv);
      chk("sw result", rv & 32'hffff,
          (i == 0) ? {16'h0, base} : {17'h0, base[15:1]});
    end
    // back to unity gain for the scan checks
    wreg(`A_CTRL, 32'h80000040);
  endtask
  // pulses at the 1 MHz limit: five cycles high, five low
  task automatic t_count;
    wreg(`A_CTRL, 32'h20);
    repeat (5) begin
      event_count_input <= 1'b1;
      repeat (5) @(posedge clk);
      event_count_input <= 1'b0;
      repeat (5) @(posedge clk);
    end
    idle(4);
    rreg(`A_COUNT, rv);
    chk("event count", rv, 32'd5);
  endtask
  task automatic t_scan;
    wreg(`A_CHEN, 32'h3);
    wreg(`A_BLOCK, 32'h2);
    wreg(`A_PACE, 32'd40);
    idle(1);
    chk("no block yet", {31'h0, block_ready}, 32'h0);
    wreg(`A_CTRL, 32'h1);
    idle(60);
    chk("block ready", {31'h0, block_ready}, 32'h1);
    rreg(`A_STATUS, rv);
    chk("scan running", rv & 32'h1c, 32'h10);
    rreg(`A_FIFO, rv);
    chk("fifo ch0", rv & 32'h7ffff, {16'h0, base});
    rreg(`A_FIFO, rv);
    chk("fifo ch1", rv & 32'h7ffff, 32'h10000 | (base + 1));
    wreg(`A_CTRL, 32'h2);
    idle(4);
    rreg(`A_STATUS, rv);
    chk("scan stopped", rv & 32'h1c, 32'h04);
  endtask
  task automatic t_trig;
    wreg(`A_TRIG, 32'h4800);
    // start source is taken from the held setting, so select it first
    wreg(`A_CTRL, 32'h10);
    wreg(`A_CTRL, 32'h11);
    idle(4);
    rreg(`A_STATUS, rv);
    chk("armed", rv & 32'h1e, 32'h0a);
    @(posedge clk);
    trig_above <= 1'b1;
    idle(4);
    rreg(`A_STATUS, rv);
    chk("triggered", rv & 32'h1c, 32'h10);
    wreg(`A_CTRL, 32'h2);
    trig_above <= 1'b0;
    // below, edge-sensitive: a low level or a rise alone must not fire
    wreg(`A_TRIG, 32'h2000);
    wreg(`A_CTRL, 32'h10);
    wreg(`A_CTRL, 32'h11);
    trig_above <= 1'b1;
    idle(4);
    rreg(`A_STATUS, rv);
    chk("edge armed", rv & 32'h1c, 32'h08);
    @(posedge clk);
    trig_above <= 1'b0;
    idle(4);
    rreg(`A_STATUS, rv);
    chk("edge fired", rv & 32'h1c, 32'h10);
    wreg(`A_CTRL, 32'h2);
  endtask
  task automatic t_ext;
    wreg(`A_CTRL, 32'h8);
    repeat (2) begin
      sample_clk_in <= ~sample_clk_in;
      idle(5);
      chk("clock out", {31'h0, sample_clk_out}, {31'h0, sample_clk_in});
      @(posedge clk);
    end
    wreg(`A_CTRL, 32'h0);
  endtask
  task automatic t_act;
    @(posedge clk);
    usb_enumerating <= 1'b1;
    idle(20);
    @(posedge clk);
    usb_enumerating <= 1'b0;
    usb_configured <= 1'b1;
    idle(6);
    chk("act steady", {31'h0, activity_indicator}, 32'h1);
    @(posedge clk);
    usb_configured <= 1'b0;
    idle(6);
    chk("act lost", {31'h0, activity_indicator}, 32'h0);
    @(posedge clk);
    usb_configured <= 1'b1;
    idle(6);
    chk("act back", {31'h0, activity_indicator}, 32'h1);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    idle(1);
    chk("dout and power after reset", {23'h0, power_indicator, digital_output_lines}, 32'h100);
    t_leds();
    t_chcfg();
    t_act();
    t_sw();
    t_count();
    t_scan();
    t_trig();
    t_ext();
    results();
  end
endmodule

// file: hdl/daq_ctrl.sv
// Purpose: acquisition controller: pacing, trigger, scan FIFO, counter, LEDs
// Assumes: converters deliver all eight results with adc_done; host reads via reg port
// Notes: block_ready stands while a full block of samples sits in the FIFO
//
// Chosen here: the placing of the registers and the strobed register port.
`include "daq_params.svh"
module daq_ctrl
  import daq_pkg::*;
#(
  parameter int BLINK_CYCLES = `BLINK_CYC
) (
  input wire logic clk, // 10 MHz system clock
  input wire logic rstn, // async reset, active low
  input wire logic [3:0] addr, // register word address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  output logic adc_start, // convert pulse to all converters
  input wire logic adc_done, // results valid on adc_data
  input wire logic [127:0] adc_data, // eight raw 16-bit results
  output logic [23:0] ch_cfg, // per-channel mode and range
  input wire logic sample_clk_in, // external pacing pin
  output logic sample_clk_out, // pacing clock copy
  input wire logic trig_above, // comparator: trigger input above level
  output logic [11:0] trig_level, // threshold dac code
  input wire logic event_count_input, // counter pin
  input wire logic [7:0] digital_input_lines, // digital input pins
  output logic [7:0] digital_output_lines, // digital output pins
  input wire logic jumper_di_led_off, // blanks input leds
  input wire logic jumper_do_led_off, // blanks output leds
  output logic [7:0] di_led, // input line leds
  output logic [7:0] do_led, // output line leds
  input wire logic usb_configured, // host enumerated us
  input wire logic usb_enumerating, // enumeration in progress
  output logic activity_indicator, // activity led
  output logic block_ready, // a block is available
  output logic power_indicator // power led
);
  // register state
  logic [7:0] chen_r;
  logic [23:0] chcfg_r;
  logic [7:0] dout_r;
  logic [31:0] count_r;
  trig_cfg_t trig_r;
  logic [31:0] pace_r;
  logic [31:0] rearm_r;
  logic [15:0] block_r;
  logic extclk_r, trigstart_r;
  logic [15:0] gain_r [0:7];
  logic [15:0] sw_r;
  logic [31:0] rdata_r;
  scan_state_t st_r, st_nxt;
  logic [31:0] pcnt_r;
  logic iclk_r;
  logic [31:0] acq_r;
  logic [2:0] ex_s, ev_s, tg_s;
  logic [7:0] di_s1, di_s2, di_s3;
  logic trig_prev_r, busy_sw_r, pend_r;
  logic [2:0] pend_ch_r;
  logic [127:0] hold_r;
  logic [7:0] pend_en_r;
  logic [31:0] blink_r;
  logic blink_r2;
  // fifo storage, declared locally
  sample_t fifo_mem [0:`FIFO_DEPTH-1];
  logic [`FIFO_AW:0] wp_r, rp_r;
  sample_t fifo_out_r;

  // decode helpers
  function automatic logic hit(input logic [3:0] a, input logic [3:0] k);
    hit = (a == k);
  endfunction

  wire wr_ctrl = wr && hit(addr, `A_CTRL);
  wire cmd_start = wr_ctrl && wdata[`CTRL_START];
  wire cmd_stop = wr_ctrl && wdata[`CTRL_STOP];
  wire cmd_sw = wr_ctrl && wdata[`CTRL_SWCONV] && (st_r == SC_IDLE);
  wire cmd_cntclr = wr_ctrl && wdata[`CTRL_CNTCLR];
  wire [`FIFO_AW:0] fill = wp_r - rp_r;
  wire fifo_full = (fill == (`FIFO_AW+1)'(`FIFO_DEPTH));
  wire fifo_empty = (fill == '0);
  wire fifo_rd = rd && hit(addr, `A_FIFO) && !fifo_empty;

  // pacing clock: internal divider or synchronised pin
  wire ex_rise = ex_s[1] && !ex_s[2];
  wire pace_min = (pace_r < `MIN_PACE_CYC) ? 1'b1 : 1'b0;
  wire [31:0] pace_eff = pace_min ? 32'(`MIN_PACE_CYC) : pace_r;
  wire int_tick = (pcnt_r >= pace_eff - 32'h00000001);
  wire pace_tick = extclk_r ? ex_rise : int_tick;
  assign sample_clk_out = extclk_r ? ex_s[1] : iclk_r;

  // trigger condition
  wire tg_now = tg_s[1];
  wire tg_hit = trig_r.edge_mode ?
    (trig_r.above ? (tg_now && !trig_prev_r) : (!tg_now && trig_prev_r)) :
    (trig_r.above ? tg_now : !tg_now);
  assign trig_level = trig_r.level;

  // scan state machine
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      SC_IDLE: begin
        if (cmd_start) st_nxt = trigstart_r ? SC_ARMED : SC_RUN;
      end
      SC_ARMED: begin
        if (cmd_stop) st_nxt = SC_IDLE;
        else if (tg_hit) st_nxt = SC_RUN;
      end
      SC_RUN: begin
        if (cmd_stop) st_nxt = SC_IDLE;
        else if (trigstart_r && trig_r.rearm && pace_tick &&
                 acq_r + 32'h00000001 >= rearm_r) st_nxt = SC_ARMED;
      end
      default: st_nxt = SC_IDLE;
    endcase
  end

  wire scan_tick = (st_r == SC_RUN) && pace_tick;
  assign adc_start = scan_tick || cmd_sw;

  // calibrated result: gain in 1.15 fixed point
  function automatic logic [15:0] cal(input logic [15:0] raw, input logic [15:0] g);
    logic [31:0] p;
    p = raw * g;
    cal = p[30:15];
  endfunction

  // synchronisers, three flops per pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ex_s <= 3'h0;
      ev_s <= 3'h0;
      tg_s <= 3'h0;
      di_s1 <= 8'h00;
      di_s2 <= 8'h00;
      di_s3 <= 8'h00;
    end else begin
      ex_s <= {ex_s[1:0], sample_clk_in};
      ev_s <= {ev_s[1:0], event_count_input};
      tg_s <= {tg_s[1:0], trig_above};
      di_s1 <= digital_input_lines;
      di_s2 <= di_s1;
      di_s3 <= di_s2;
    end
  end

  // a line changes once second and third stages agree
  logic [7:0] di_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) di_r <= 8'h00;
    else di_r <= (di_s2 & di_s3) | (di_r & (di_s2 | di_s3));
  end
  wire ev_rise = ev_s[1] && !ev_s[2];

  // event counter; 10 MHz sampling covers a 1 MHz input
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) count_r <= 32'h00000000;
    else if (cmd_cntclr) count_r <= 32'h00000000;
    else if (ev_rise) count_r <= count_r + 32'h00000001;
  end

  // host registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chen_r <= 8'h01;
      chcfg_r <= 24'h000000;
      dout_r <= 8'h00;
      trig_r <= '0;
      pace_r <= `PACE_RST;
      rearm_r <= 32'h00000001;
      block_r <= `BLOCK_RST;
      extclk_r <= 1'b0;
      trigstart_r <= 1'b0;
    end else if (wr) begin
      if (hit(addr, `A_CHEN)) chen_r <= wdata[7:0];
      if (hit(addr, `A_CHCFG)) chcfg_r <= wdata[23:0];
      if (hit(addr, `A_DOUT)) dout_r <= wdata[7:0];
      if (hit(addr, `A_TRIG)) trig_r <= wdata[14:0];
      if (hit(addr, `A_PACE)) pace_r <= wdata;
      if (hit(addr, `A_REARM)) rearm_r <= wdata;
      if (hit(addr, `A_BLOCK)) block_r <= wdata[15:0];
      if (wr_ctrl) extclk_r <= wdata[`CTRL_EXTCLK];
      if (wr_ctrl) trigstart_r <= wdata[`CTRL_TRIGSTART];
    end
  end
  assign ch_cfg = chcfg_r;
  assign digital_output_lines = dout_r;

  // calibration gains, held after a write; reset loads unity gain 16'h8000
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_cal
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) gain_r[gi] <= 16'h8000;
        else if (wr_ctrl && wdata[`CTRL_CALWR] && wdata[10:8] == 3'(gi))
          gain_r[gi] <= wdata[31:16];
      end
    end
  endgenerate

  // pacing counter, scan state, trigger history, acquired count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= SC_IDLE;
      pcnt_r <= 32'h00000000;
      iclk_r <= 1'b0;
      trig_prev_r <= 1'b0;
      acq_r <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
      pcnt_r <= int_tick ? 32'h00000000 : pcnt_r + 32'h00000001;
      iclk_r <= (pcnt_r < (pace_eff >> 1)) ? 1'b1 : 1'b0;
      trig_prev_r <= tg_now;
      if (st_r != SC_RUN) acq_r <= 32'h00000000;
      else if (pace_tick) acq_r <= acq_r + 32'h00000001;
    end
  end

  // store results: one group per tick, channels in order
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_r <= 1'b0;
      pend_ch_r <= 3'h0;
      pend_en_r <= 8'h00;
      hold_r <= '0;
      busy_sw_r <= 1'b0;
      sw_r <= 16'h0000;
      wp_r <= '0;
    end else begin
      if (adc_done && busy_sw_r) begin
        busy_sw_r <= 1'b0;
        sw_r <= cal(adc_data[15:0], gain_r[0]);
      end else if (adc_done) begin
        hold_r <= adc_data;
        pend_en_r <= chen_r;
        pend_ch_r <= 3'h0;
        pend_r <= 1'b1;
      end else if (pend_r) begin
        if (pend_en_r[pend_ch_r] && !fifo_full) begin
          fifo_mem[wp_r[`FIFO_AW-1:0]] <= '{ch: pend_ch_r,
            code: cal(hold_r[16*pend_ch_r +: 16], gain_r[pend_ch_r])};
          wp_r <= wp_r + 1'b1;
        end
        if (!pend_en_r[pend_ch_r] || !fifo_full) begin
          pend_ch_r <= pend_ch_r + 3'h1;
          if (pend_ch_r == 3'h7) pend_r <= 1'b0;
        end
      end
      // a new command wins over the done of the previous one
      if (cmd_sw) busy_sw_r <= 1'b1;
    end
  end

  // host drains the fifo; blocks are announced, not single samples
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rp_r <= '0;
      fifo_out_r <= '0;
    end else if (fifo_rd) begin
      fifo_out_r <= fifo_mem[rp_r[`FIFO_AW-1:0]];
      rp_r <= rp_r + 1'b1;
    end
  end
  assign block_ready = (32'(fill) >= 32'(block_r)) && (block_r != 16'h0000);

  // read mux
  logic [31:0] rmux;
  always_comb begin
    case (addr)
      `A_CHEN: rmux = {24'h000000, chen_r};
      `A_CHCFG: rmux = {8'h00, chcfg_r};
      `A_DOUT: rmux = {24'h000000, dout_r};
      `A_DIN: rmux = {24'h000000, di_r};
      `A_COUNT: rmux = count_r;
      `A_TRIG: rmux = {17'h00000, trig_r};
      `A_PACE: rmux = pace_r;
      `A_REARM: rmux = rearm_r;
      `A_STATUS: rmux = {21'h000000, 3'(fill >> 6), fifo_full, fifo_empty, busy_sw_r, st_r,
                         trigstart_r, extclk_r};
      `A_SWDATA: rmux = {16'h0000, sw_r};
      `A_BLOCK: rmux = {16'h0000, block_r};
      default: rmux = 32'h00000000;
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rdata_r <= 32'h00000000;
    else if (rd) rdata_r <= rmux;
    else rdata_r <= 32'h00000000;
  end
  logic fifo_sel_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) fifo_sel_r <= 1'b0;
    else fifo_sel_r <= rd && hit(addr, `A_FIFO);
  end
  // fifo data comes straight from the output register in the answer cycle
  assign rdata = fifo_sel_r ? {13'h0000, fifo_out_r} : rdata_r;

  // leds: line level drives its led, jumpers blank a group
  assign di_led = jumper_di_led_off ? 8'h00 : di_r;
  assign do_led = jumper_do_led_off ? 8'h00 : dout_r;
  assign power_indicator = 1'b1;

  // activity blink timer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blink_r <= 32'h00000000;
      blink_r2 <= 1'b0;
    end else if (blink_r >= 32'(BLINK_CYCLES) - 32'h00000001) begin
      blink_r <= 32'h00000000;
      blink_r2 <= !blink_r2;
    end else blink_r <= blink_r + 32'h00000001;
  end
  // transfers are running while a scan is active, a software conversion is pending or data waits
  wire xfer = (st_r != SC_IDLE) || !fifo_empty || busy_sw_r;
  assign activity_indicator =
    usb_enumerating ? blink_r2 :
    !usb_configured ? 1'b0 :
    xfer ? blink_r2 : 1'b1;
endmodule

// file: include/daq_params.svh
// Purpose: constants of the simultaneous acquisition controller
// Assumes: 10 MHz clk, plain register port with one-cycle read latency
// Notes: offsets are word addresses on the register port
// Behaviour
// - eight converters sampled together, 16-bit results
// - per-channel input mode and range, host set
// - digital outputs low at power-up and reset
// - each digital line lights its own LED
// - jumpers blank input LEDs or output LEDs
// - 32-bit counter of event input pulses
// - external pacing uses sample clock input
// - clock output copies the active pacing clock
// - trigger condition can start conversions
// - software mode: one command, one result
// - scan keeps filling FIFO until stopped
// - scan data leaves FIFO in blocks
// - scan rate up to 250 kS/s
// - scan starts by command or trigger
// - activity LED steady when enumerated
// - activity LED blinks during data transfer
// - blinks while enumerating, then steady
// - activity LED dark when link lost
// - calibration coefficients applied to results
// - counter counts rising edges up to 1 MHz
// - trigger above/below, level/edge, rearm on/off
// - rearm after sample count, same settings
`ifndef DAQ_PARAMS_SVH
`define DAQ_PARAMS_SVH
`define A_CTRL 4'h0
`define A_CHEN 4'h1
`define A_CHCFG 4'h2
`define A_DOUT 4'h3
`define A_DIN 4'h4
`define A_COUNT 4'h5
`define A_TRIG 4'h6
`define A_PACE 4'h7
`define A_REARM 4'h8
`define A_STATUS 4'h9
`define A_FIFO 4'ha
`define A_SWDATA 4'hb
`define A_CAL 4'hc
`define A_BLOCK 4'hd
`define CTRL_START 0
`define CTRL_STOP 1
`define CTRL_SWCONV 2
`define CTRL_EXTCLK 3
`define CTRL_TRIGSTART 4
`define CTRL_CNTCLR 5
`define CTRL_CALWR 6
`define CLK_HZ 10000000
`define MAX_RATE_SPS 250000
`define MIN_PACE_CYC ((`CLK_HZ + `MAX_RATE_SPS - 1) / `MAX_RATE_SPS)
`define PACE_RST 32'h00000028
`define BLOCK_RST 16'h0040
`define BLINK_MS 100
`define BLINK_CYC ((`CLK_HZ / 1000) * `BLINK_MS)
`define FIFO_DEPTH 256
`define FIFO_AW 8
`endif

// file: include/daq_pkg.sv
// Purpose: types of the acquisition controller
// Assumes: nothing beyond the params header
// Notes: one-hot state codes
package daq_pkg;
  typedef enum logic [2:0] {
    SC_IDLE = 3'b001,
    SC_ARMED = 3'b010,
    SC_RUN = 3'b100
  } scan_state_t;
  typedef struct packed {
    logic above;
    logic edge_mode;
    logic rearm;
    logic [11:0] level;
  } trig_cfg_t;
  typedef struct packed {
    logic diff;
    logic [1:0] range;
  } ch_cfg_t;
  typedef struct packed {
    logic [2:0] ch;
    logic [15:0] code;
  } sample_t;
endpackage
